// *** src/i2st_top.sv ***
// i2c start/stop trigger engine with apb register access
module i2st_top
    import i2st_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_lclk,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_scl_oe,
    output logic o_sda,
    output logic o_sda_oe
);
    // ------------------------------------------------------------
    // register side (i_mclk)
    // ------------------------------------------------------------
    i2st_ctrl_t ctrl_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic start_tg_r;
    logic stop_tg_r;
    logic wait_release_tg_r;
    logic wait_d_r;
    i2st_stat_t stat_m;
    logic access;
    logic wr_ctrl;

    // ------------------------------------------------------------
    // link side (i_lclk)
    // ------------------------------------------------------------
    i2st_state_t st_r;
    logic [7:0] cnt_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic scl_oe_r;
    logic sda_oe_r;
    logic master_r;
    logic trc_r;
    logic busy_r;
    logic rd_dir_r;
    logic addr_ph_r;
    logic ackd_r;
    logic sda_d_r;
    logic [2:0] tg_d_r;
    logic [2:0] tg_s;
    logic [1:0] pin_s;
    i2st_ctrl_t ctrl_s;
    i2st_stat_t stat_l;
    logic start_p;
    logic stop_p;
    logic wait_release_p;
    logic scl_s;
    logic sda_s;

    function automatic logic is_reg(input logic [11:0] a, input logic [11:0] r);
        is_reg = (a == r);
    endfunction

    // ------------------------------------------------------------
    // apb slave: one wait state, then pready
    // ------------------------------------------------------------
    assign access = i_psel && i_penable && !o_pready;
    assign wr_ctrl = access && i_pwrite && is_reg(i_paddr, ADDR_CTRL);

    // answer phase and read data
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= access;
            o_pslverr <= 1'b0;
            if (access) begin
                o_prdata <= 32'h0000_0000;
                if (is_reg(i_paddr, ADDR_CTRL)) begin
                    // trigger bits always read zero
                    o_prdata[CTRL_EN] <= ctrl_r.enable;
                    o_prdata[CTRL_ACK_ENABLE] <= ctrl_r.ack_enable;
                    o_prdata[CTRL_WAIT_TIMING_SELECT] <= ctrl_r.wait_timing_select;
                end else if (is_reg(i_paddr, ADDR_STAT)) begin
                    o_prdata[7:0] <= stat_m;
                end else if (is_reg(i_paddr, ADDR_DATA)) begin
                    o_prdata[7:0] <= rx_r;
                end else begin
                    o_pslverr <= 1'b1;
                end
            end
        end
    end

    // software settings
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= '0;
            tx_r <= DATA_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r.enable <= i_pwdata[CTRL_EN];
                ctrl_r.ack_enable <= i_pwdata[CTRL_ACK_ENABLE];
                ctrl_r.wait_timing_select <= i_pwdata[CTRL_WAIT_TIMING_SELECT];
            end
            if (access && i_pwrite && is_reg(i_paddr, ADDR_DATA)) begin
                tx_r <= i_pwdata[7:0];
            end
        end
    end

    // triggers become toggles; no stored bit, so nothing to clear
    // stop wins if both are written together, start is dropped
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_tg_r <= 1'b0;
            stop_tg_r <= 1'b0;
            wait_release_tg_r <= 1'b0;
        end else if (wr_ctrl) begin
            if (i_pwdata[CTRL_STOP]) begin
                stop_tg_r <= !stop_tg_r;
            end else if (i_pwdata[CTRL_START]) begin
                start_tg_r <= !start_tg_r;
            end
            if (i_pwdata[CTRL_WAIT_RELEASE]) begin
                wait_release_tg_r <= !wait_release_tg_r;
            end
        end
    end

    // status back into the register domain
    i2st_sync #(.W(8)) u_stat_sync (
        .i_clk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_d(stat_l),
        .o_q(stat_m)
    );

    // shift register is frozen during a wait, so sampling it then is safe
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_d_r <= 1'b0;
            rx_r <= DATA_RST;
        end else begin
            wait_d_r <= stat_m.waiting;
            if (stat_m.waiting && !wait_d_r) begin
                rx_r <= sh_r;
            end
        end
    end

    // ------------------------------------------------------------
    // crossings into the link domain
    // ------------------------------------------------------------
    // tx_r is written before its toggle, so it is stable when used
    i2st_sync #(.W(3)) u_tg_sync (
        .i_clk(i_lclk),
        .i_rst_n(i_rst_n),
        .i_d({start_tg_r, stop_tg_r, wait_release_tg_r}),
        .o_q(tg_s)
    );

    i2st_sync #(.W(3)) u_ctrl_sync (
        .i_clk(i_lclk),
        .i_rst_n(i_rst_n),
        .i_d(ctrl_r),
        .o_q(ctrl_s)
    );

    i2st_sync #(.W(2)) u_pin_sync (
        .i_clk(i_lclk),
        .i_rst_n(i_rst_n),
        .i_d({!i_scl, !i_sda}),
        .o_q(pin_s)
    );

    // lines carried inverted so the cleared synchroniser reads as an idle, pulled-up bus:
    // no false start or stop edge right after reset
    assign scl_s = !pin_s[1];
    assign sda_s = !pin_s[0];
    assign start_p = tg_s[2] ^ tg_d_r[2];
    assign stop_p = tg_s[1] ^ tg_d_r[1];
    assign wait_release_p = tg_s[0] ^ tg_d_r[0];

    // ------------------------------------------------------------
    // bus watch: start/stop detection from other masters
    // ------------------------------------------------------------
    always_ff @(posedge i_lclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tg_d_r <= 3'h0;
            sda_d_r <= 1'b1;
            busy_r <= 1'b0;
        end else begin
            tg_d_r <= tg_s;
            sda_d_r <= sda_s;
            if (scl_s && sda_d_r && !sda_s) begin
                busy_r <= 1'b1;
            end else if (scl_s && !sda_d_r && sda_s) begin
                busy_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // condition and byte engine
    // ------------------------------------------------------------
    always_ff @(posedge i_lclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= ST_IDLE;
            cnt_r <= 8'h00;
            bit_r <= 4'h0;
            sh_r <= DATA_RST;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            master_r <= 1'b0;
            trc_r <= 1'b0;
            rd_dir_r <= 1'b0;
            addr_ph_r <= 1'b0;
            ackd_r <= 1'b0;
        end else if (!ctrl_s.enable) begin
            st_r <= ST_IDLE;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            master_r <= 1'b0;
            trc_r <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    cnt_r <= 8'h00;
                    if (start_p) begin
                        if (busy_r) begin
                            st_r <= ST_PEND;
                        end else begin
                            sda_oe_r <= 1'b1;
                            st_r <= ST_START;
                        end
                    end else if (stop_p) begin
                        // any stop in idle is allowed, also as non-master
                        st_r <= ST_STOPA;
                    end
                end
                ST_PEND: begin
                    // request held until the bus frees or a stop trigger drops it, then consumed once
                    if (stop_p) begin
                        st_r <= ST_IDLE;
                    end else if (!busy_r) begin
                        sda_oe_r <= 1'b1;
                        cnt_r <= 8'h00;
                        st_r <= ST_START;
                    end
                end
                ST_START: begin
                    if (cnt_r == HOLD_CYC - 8'd1) begin
                        scl_oe_r <= 1'b1;
                        master_r <= 1'b1;
                        trc_r <= 1'b1;
                        addr_ph_r <= 1'b1;
                        bit_r <= 4'h0;
                        sh_r <= tx_r;
                        cnt_r <= 8'h00;
                        st_r <= ST_LOW;
                    end else begin
                        cnt_r <= cnt_r + 8'd1;
                    end
                end
                ST_LOW: begin
                    scl_oe_r <= 1'b1;
                    if (cnt_r == 8'h00) begin
                        if (bit_r == BIT_ACK) begin
                            // ack only as receiver, never on the address byte
                            sda_oe_r <= !trc_r && ctrl_s.ack_enable && !addr_ph_r;
                        end else begin
                            sda_oe_r <= trc_r && !sh_r[7];
                        end
                    end
                    if (cnt_r == HALF_CYC - 8'd1) begin
                        scl_oe_r <= 1'b0;
                        cnt_r <= 8'h00;
                        st_r <= ST_HIGH;
                    end else begin
                        cnt_r <= cnt_r + 8'd1;
                    end
                end
                ST_HIGH: begin
                    // count only while scl is really high: honours stretching
                    if (scl_s) begin
                        if (cnt_r == HALF_CYC - 8'd1) begin
                            cnt_r <= 8'h00;
                            scl_oe_r <= 1'b1;
                            bit_r <= bit_r + 4'd1;
                            if (bit_r == BIT_ACK) begin
                                ackd_r <= !sda_s;
                                if (addr_ph_r) begin
                                    rd_dir_r <= sh_r[0];
                                end
                                addr_ph_r <= 1'b0;
                                st_r <= ST_WAIT;
                            end else begin
                                sh_r <= {sh_r[6:0], sda_s};
                                if (bit_r == BIT_EIGHT && !ctrl_s.wait_timing_select) begin
                                    st_r <= ST_WAIT;
                                end else begin
                                    st_r <= ST_LOW;
                                end
                            end
                        end else begin
                            cnt_r <= cnt_r + 8'd1;
                        end
                    end
                end
                ST_WAIT: begin
                    scl_oe_r <= 1'b1;
                    cnt_r <= 8'h00;
                    if (start_p) begin
                        sda_oe_r <= 1'b0;
                        st_r <= ST_RS;
                    end else if (stop_p) begin
                        st_r <= ST_STOPA;
                    end else if (wait_release_p) begin
                        st_r <= ST_LOW;
                        if (bit_r == BIT_DONE) begin
                            bit_r <= 4'h0;
                            sh_r <= tx_r;
                            if (rd_dir_r && trc_r) begin
                                // read phase begins: hand sda to the slave
                                trc_r <= 1'b0;
                                sda_oe_r <= 1'b0;
                            end
                        end
                    end
                end
                ST_RS: begin
                    // sda released while scl low, then scl up and held
                    if (scl_oe_r) begin
                        if (cnt_r == HALF_CYC - 8'd1) begin
                            scl_oe_r <= 1'b0;
                            cnt_r <= 8'h00;
                        end else begin
                            cnt_r <= cnt_r + 8'd1;
                        end
                    end else if (scl_s) begin
                        if (cnt_r == HOLD_CYC - 8'd1) begin
                            sda_oe_r <= 1'b1;
                            cnt_r <= 8'h00;
                            st_r <= ST_START;
                        end else begin
                            cnt_r <= cnt_r + 8'd1;
                        end
                    end
                end
                ST_STOPA: begin
                    scl_oe_r <= 1'b1;
                    sda_oe_r <= 1'b1;
                    if (cnt_r == HALF_CYC - 8'd1) begin
                        scl_oe_r <= 1'b0;
                        cnt_r <= 8'h00;
                        st_r <= ST_STOPB;
                    end else begin
                        cnt_r <= cnt_r + 8'd1;
                    end
                end
                ST_STOPB: begin
                    // wait for scl to be seen high, then the hold time
                    if (scl_s) begin
                        if (cnt_r == HOLD_CYC - 8'd1) begin
                            sda_oe_r <= 1'b0;
                            master_r <= 1'b0;
                            trc_r <= 1'b0;
                            cnt_r <= 8'h00;
                            st_r <= ST_IDLE;
                        end else begin
                            cnt_r <= cnt_r + 8'd1;
                        end
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // status word gathered in the link domain, levels only
    assign stat_l = '{master: master_r, pending: st_r == ST_PEND, waiting: st_r == ST_WAIT,
        busy: busy_r, transmit_direction_status: trc_r, ackd: ackd_r, rd_dir: rd_dir_r,
        ninth: bit_r == BIT_DONE};

    // pins: open drain, low level only, enables straight from flops
    assign o_scl_oe = scl_oe_r;
    assign o_sda_oe = sda_oe_r;
    always_ff @(posedge i_lclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_scl <= 1'b0;
            o_sda <= 1'b0;
        end else begin
            o_scl <= 1'b0;
            o_sda <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    localparam int A_HOLD = HOLD_CYC;

    AST_START_SEQ: assert property (@(posedge i_lclk) disable iff (!i_rst_n)
        (ctrl_s.enable && st_r == ST_IDLE && start_p && !busy_r)
        |=> (sda_oe_r && !scl_oe_r) ##A_HOLD scl_oe_r)
        else $error("start did not lower sda then scl after hold");
    AST_PEND_HOLD: assert property (@(posedge i_lclk) disable iff (!i_rst_n)
        (ctrl_s.enable && st_r == ST_IDLE && start_p && busy_r) |=> st_r == ST_PEND && !sda_oe_r)
        else $error("start on busy bus not held pending");
    AST_PEND_GO: assert property (@(posedge i_lclk) disable iff (!i_rst_n)
        (ctrl_s.enable && st_r == ST_PEND && !busy_r && !stop_p) |=> st_r == ST_START && sda_oe_r)
        else $error("pending start not issued after bus release");
    AST_RESTART: assert property (@(posedge i_lclk) disable iff (!i_rst_n)
        (ctrl_s.enable && st_r == ST_WAIT && start_p) |=> st_r == ST_RS && !sda_oe_r && scl_oe_r)
        else $error("start in wait did not begin repeated start");
    AST_ACK_DRIVE: assert property (@(posedge i_lclk) disable iff (!i_rst_n)
        (ctrl_s.enable && st_r == ST_LOW && bit_r == BIT_ACK && cnt_r == 8'h01)
        |-> sda_oe_r == (!trc_r && $past(ctrl_s.ack_enable) && !addr_ph_r))
        else $error("ninth clock ack drive wrong");
    AST_WAIT8: assert property (@(posedge i_lclk) disable iff (!i_rst_n)
        (ctrl_s.enable && st_r == ST_HIGH && scl_s && cnt_r == HALF_CYC - 8'd1 && bit_r == BIT_EIGHT
        && !ctrl_s.wait_timing_select) |=> st_r == ST_WAIT && scl_oe_r)
        else $error("no wait after eight clocks");
    AST_STOP_END: assert property (@(posedge i_lclk) disable iff (!i_rst_n)
        (ctrl_s.enable && st_r == ST_STOPA && cnt_r == HALF_CYC - 8'd1)
        |=> (st_r == ST_STOPB && sda_oe_r && !scl_oe_r) ##1 sda_oe_r)
        else $error("stop sequence broke order");
    AST_TRC_CLR: assert property (@(posedge i_lclk) disable iff (!i_rst_n)
        (ctrl_s.enable && st_r == ST_WAIT && wait_release_p && !start_p && !stop_p && bit_r == BIT_DONE
        && rd_dir_r && trc_r) |=> !trc_r && !sda_oe_r)
        else $error("wait release did not clear direction");
    AST_TRIG_RD0: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_psel && i_penable && o_pready && !i_pwrite && is_reg(i_paddr, ADDR_CTRL))
        |-> o_prdata[CTRL_START:CTRL_STOP] == 2'b00)
        else $error("trigger bit read back non-zero");
    AST_TRIG_ONCE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (wr_ctrl && i_pwdata[CTRL_START] && !i_pwdata[CTRL_STOP])
        |=> start_tg_r != $past(start_tg_r) ##1 $stable(start_tg_r))
        else $error("start toggle not single");
    AST_PREADY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready)
        else $error("pready not one cycle after access");

    COV_START: cover property (@(posedge i_lclk) disable iff (!i_rst_n) st_r == ST_START ##1 st_r == ST_LOW);
    COV_PEND: cover property (@(posedge i_lclk) disable iff (!i_rst_n) st_r == ST_PEND ##1 st_r == ST_START);
    COV_RS: cover property (@(posedge i_lclk) disable iff (!i_rst_n) st_r == ST_RS ##1 st_r == ST_START);
    COV_STOP: cover property (@(posedge i_lclk) disable iff (!i_rst_n) st_r == ST_STOPB ##1 st_r == ST_IDLE);
endmodule

// *** src/i2st_pkg.sv ***
// shared constants, types and states of the i2c start/stop trigger block
package i2st_pkg;
    // ------------------------------------------------------------
    // apb register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_DATA = 12'h008;

    // control register bit positions
    localparam int CTRL_STOP = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_ACK_ENABLE = 2;
    localparam int CTRL_WAIT_TIMING_SELECT = 3;
    localparam int CTRL_WAIT_RELEASE = 5;
    localparam int CTRL_EN = 7;

    // reset values
    localparam logic [7:0] DATA_RST = 8'h00;

    // ------------------------------------------------------------
    // bus timing on the link clock
    // ------------------------------------------------------------
    localparam int LCLK_NS = 80;
    localparam int HALF_NS = 5000;
    localparam int HOLD_NS = 4000;
    // least times round up to whole link cycles
    localparam logic [7:0] HALF_CYC = 8'((HALF_NS + LCLK_NS - 1) / LCLK_NS);
    localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS + LCLK_NS - 1) / LCLK_NS);

    // bit counter marks
    localparam logic [3:0] BIT_EIGHT = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;

    // software settings carried into the link domain
    typedef struct packed {
        logic enable;
        logic ack_enable;
        logic wait_timing_select;
    } i2st_ctrl_t;

    // status carried back; bit 3 is the transmit direction
    typedef struct packed {
        logic master;
        logic pending;
        logic waiting;
        logic busy;
        logic transmit_direction_status;
        logic ackd;
        logic rd_dir;
        logic ninth;
    } i2st_stat_t;

    // engine states, gray coded from idle through stopb; stopb back to idle and wait back to low change two bits
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_START = 4'h1,
        ST_LOW = 4'h3,
        ST_HIGH = 4'h2,
        ST_WAIT = 4'h6,
        ST_STOPA = 4'h7,
        ST_STOPB = 4'h5,
        ST_PEND = 4'h4,
        ST_RS = 4'hc
    } i2st_state_t;
endpackage

// *** src/i2st_sync.sv ***
// two flip-flop level synchroniser
module i2st_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            o_q <= '0;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule

// *** verif/i2st_far.sv ***
// far side of the i2c bus: pull-ups and another master that can hold sda
module i2st_far (
    input wire logic i_scl_oe,
    input wire logic i_sda_oe,
    input wire logic i_hold,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // open drain: low while anyone pulls, pull-up high otherwise
    assign o_scl = !i_scl_oe;
    // other master: sda low with scl high is its start, release is its stop
    assign o_sda = !(i_sda_oe || i_hold);
endmodule

// *** verif/i2st_top_tb.sv ***
// self-checking bench for the i2c start/stop trigger block
module i2st_top_tb
    import i2st_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0, lclk = 1'h0, rst_n = 1'h0, busy = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e, pready, pslverr, scl, sda, scl_oe, sda_oe;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q, prdata;
    int n_mismatch = 0, compares = 0, n;
    logic [11:0] ra [4] = '{ADDR_CTRL, ADDR_STAT, ADDR_DATA, 12'h00c};
    logic re [4] = '{1'h0, 1'h0, 1'h0, 1'h1};
    // register clock; link clock offset so the phases never line up
    always #2.5 mclk = ~mclk;
    initial begin
        #13;
        forever #40 lclk = ~lclk;
    end
    i2st_top i2st_top_inst (.i_mclk(mclk), .i_rst_n(rst_n), .i_lclk(lclk), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .i_sda(sda), .o_scl(), .o_scl_oe(scl_oe),
        .o_sda(), .o_sda_oe(sda_oe));
    i2st_far i2st_far_inst (.i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .i_hold(busy), .o_scl(scl), .o_sda(sda));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen, then an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (pready !== 1'h1) n_mismatch++;
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask
    // count link cycles until an enable reaches a level; sampled mid-cycle
    task automatic till(input logic sel, input logic v);
        n = 0;
        while ((sel ? scl_oe : sda_oe) !== v && n < 3000) begin
            @(negedge lclk);
            n++;
        end
        @(posedge mclk);
    endtask
    // read status until every bit of the mask is set; running out counts as a mismatch
    task automatic poll(input logic [7:0] m);
        q = 32'h0;
        for (int k = 0; k < 9000 && (q[7:0] & m) !== m; k++) apb(1'h0, ADDR_STAT, 32'h0);
        if ((q[7:0] & m) !== m) n_mismatch++;
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog well beyond the longest expected run
    initial begin
        #450000;
        n_mismatch++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge lclk);
        @(posedge mclk);
        rst_n <= 1'h1;
        @(posedge mclk);
        chk(32'({scl_oe, sda_oe}), 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'h0, ra[i], 32'h0);
            chk(q, 32'h0);
            chk(32'(e), 32'(re[i]));
        end
        apb(1'h1, ADDR_DATA, 32'ha0);
        apb(1'h1, ADDR_CTRL, 32'h82); // start only, never with stop
        apb(1'h0, ADDR_CTRL, 32'h0);
        chk(q, 32'h80);
        till(1'h0, 1'h1);
        chk(32'(scl_oe), 32'h0);
        till(1'h1, 1'h1);
        chk(32'(n), 32'(HOLD_CYC));
        poll(8'h20);
        chk(32'(q[7:5]), 32'h5);
        chk(32'(scl_oe), 32'h1);
        chk(32'(q[0]), 32'h0);
        apb(1'h0, ADDR_DATA, 32'h0);
        chk(q, 32'ha0);
        apb(1'h1, ADDR_DATA, 32'ha1);
        // eight-clock wait: switch to ninth-clock timing and release
        apb(1'h1, ADDR_CTRL, 32'ha8);
        poll(8'h21);
        apb(1'h1, ADDR_CTRL, 32'h8a); // restart inside the transmit wait, not the ack period
        till(1'h1, 1'h0);
        chk(32'(sda_oe), 32'h0);
        till(1'h0, 1'h1);
        chk(32'(scl), 32'h1);
        poll(8'h21);
        chk(32'(q[3:1]), 32'h5);
        // read phase: ack stays disabled and no start is set mid-receive
        apb(1'h1, ADDR_CTRL, 32'ha8);
        repeat (4) @(posedge lclk);
        @(posedge mclk);
        apb(1'h0, ADDR_STAT, 32'h0);
        chk(32'({q[5], q[3], sda_oe}), 32'h0);
        poll(8'h21);
        apb(1'h1, ADDR_CTRL, 32'h89); // stop as master, inside the wait
        apb(1'h0, ADDR_CTRL, 32'h0);
        chk(q, 32'h88);
        till(1'h1, 1'h0);
        chk(32'(sda_oe), 32'h1);
        till(1'h0, 1'h0);
        chk(32'({scl, n >= HOLD_CYC}), 32'h3);
        apb(1'h0, ADDR_STAT, 32'h0);
        apb(1'h0, ADDR_STAT, 32'h0);
        chk(32'(q[7]), 32'h0);
        // bus taken by another master, then a start is reserved
        busy <= 1'h1;
        repeat (10) @(posedge lclk);
        @(posedge mclk);
        apb(1'h1, ADDR_CTRL, 32'h8a);
        repeat (60) @(posedge lclk);
        @(posedge mclk);
        apb(1'h0, ADDR_STAT, 32'h0);
        chk(32'({q[6], sda_oe}), 32'h2);
        busy <= 1'h0;
        till(1'h0, 1'h1);
        chk(32'({n < 300, scl_oe}), 32'h2);
        // reset in mid-transfer: lines freed, control and status back to zero
        rst_n <= 1'h0;
        repeat (2) @(posedge lclk);
        @(posedge mclk);
        chk(32'({scl_oe, sda_oe, pready}), 32'h0);
        rst_n <= 1'h1;
        @(posedge mclk);
        apb(1'h0, ADDR_CTRL, 32'h0);
        chk(q, 32'h0);
        apb(1'h0, ADDR_STAT, 32'h0);
        chk(q, 32'h0);
        tally_and_finish();
    end
endmodule
